//--- hdl/rifd_pkg.sv
// package for the run input function decoder of a drive control core
// assumes one 100 MHz control clock and terminals that are already clean levels
package rifd_pkg;
  localparam int NTERM = 8;
  localparam int BIAS_W = 16;
  localparam int REF_W = 4;
  localparam int CLK_MHZ = 100;
  localparam int FOLD_TIME_S = 5;
  localparam int FOLD_CYCLES = FOLD_TIME_S * CLK_MHZ * 1000000;
  localparam int BIAS_TICK_US = 10;
  localparam int BIAS_TICK_CYC = BIAS_TICK_US * CLK_MHZ;
  localparam int NFN = 18;
  // function index into the code table
  localparam int F_PIDL = 0, F_FWD = 1, F_REV = 2, F_RUN2 = 3, F_DIR2 = 4;
  localparam int F_STD = 5, F_STC = 6, F_DCB = 7, F_SS1 = 8, F_SS2 = 9;
  localparam int F_FW = 10, F_KNC = 11, F_KNO = 12, F_CTST = 13, F_HSB = 14;
  localparam int F_EN = 15, F_UP2 = 16, F_DN2 = 17;
  localparam logic [NFN*8-1:0] FN_CODES = {
    8'h76, 8'h75, 8'h6a, 8'h68, 8'h67, 8'h66, 8'h65, 8'h63, 8'h62,
    8'h61, 8'h60, 8'h52, 8'h51, 8'h43, 8'h42, 8'h41, 8'h40, 8'h35};
  localparam int TERM_FIRST = 0;
  localparam int TERM_SECOND = 1;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  typedef logic [7:0] rifd_fn_t;
  // drive settings that steer decoding
  typedef struct packed {
    logic two_wire_init;
    logic vf_control;
    logic speed_search_at_start;
    logic [1:0] stop_method_select;
    logic multi_step_ref;
    logic [BIAS_W-1:0] bias_step_amount;
    logic signed [BIAS_W-1:0] bias_upper_limit;
    logic signed [BIAS_W-1:0] bias_lower_limit;
  } rifd_cfg_t;
  // decoded command word
  typedef struct packed {
    logic run;
    logic reverse;
    logic external_fault_code;
    logic input_assignment_error;
    logic disabled_indication;
    logic stop_req;
    logic [1:0] stop_method;
    logic dc_brake;
    logic speed_search;
    logic field_weaken;
    logic kinetic_ride_through;
    logic high_slip_braking;
    logic pid_invert;
    logic seq_timer_disable;
    logic seq_timer_cancel;
    logic comm_test;
    logic comm_test_ok;
    logic bias_fold;
  } rifd_cmd_t;
endpackage

//--- hdl/rifd_decoder.sv
// top of the run input function decoder
// assumes function codes and settings stay put while running; one clock domain
// outputs are all registered; no other clock or reset enters
`timescale 1ns/1ns
module rifd_decoder #(
  parameter int NT = rifd_pkg::NTERM,
  parameter int FOLD_CYC = rifd_pkg::FOLD_CYCLES
) (
  input wire logic clk, // 100 MHz control clock
  input wire logic reset_n, // async active-low reset
  input wire logic [NT-1:0] term_in, // raw input terminals, 1 = closed
  input wire rifd_pkg::rifd_fn_t [NT-1:0] input_function_select, // per-terminal code
  input wire rifd_pkg::rifd_cfg_t cfg, // drive settings
  input wire logic motor_stopped, // motor at standstill
  input wire logic jog_cmd, // jog request from operator
  input wire logic [rifd_pkg::REF_W-1:0] ref_step, // active multi-step index
  input wire logic comm_rx, // serial receive line
  output logic comm_tx_r, // serial transmit line
  output rifd_pkg::rifd_cmd_t cmd_r, // decoded commands
  output logic signed [rifd_pkg::BIAS_W-1:0] bias_r // frequency bias
);
  import rifd_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_r; // first release stage
  logic rst_sync_r; // internal reset, low while held
  // async assert, sync release through two flops
  // release is delayed two edges so every flop leaves reset on the same edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------
  // terminal synchroniser
  // ----------------------------------------
  logic [NT-1:0] term_meta_r; // first stage, may be metastable
  logic [NT-1:0] term_r; // settled snapshot
  logic [NT-1:0] term_meta_nxt;
  logic [NT-1:0] term_nxt;
  // second stage is the snapshot every check uses
  // only the second stage is decoded, so a late edge never splits the combination checks
  always_comb begin
    term_meta_nxt = term_in;
    term_nxt = term_meta_r;
  end
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      term_meta_r <= '0;
      term_r <= '0;
    end else begin
      term_meta_r <= term_meta_nxt;
      term_r <= term_nxt;
    end
  end

  // ----------------------------------------
  // function decode per terminal
  // ----------------------------------------
  rifd_fn_t [NT-1:0] fn_eff; // code in force per terminal
  logic [NFN-1:0][NT-1:0] hit; // function on terminal
  logic [NFN-1:0] asg; // function assigned somewhere
  logic [NFN-1:0] act; // function assigned and closed
  genvar gt, gf;
  // a code that matches no function is simply ignored
  generate
    for (gt = 0; gt < NT; gt++) begin : g_term
      // two-wire init overrides the first two terminals
      if (gt == TERM_FIRST) begin : g_first
        assign fn_eff[gt] = cfg.two_wire_init ? FN_CODES[F_FWD*8 +: 8]
                                              : input_function_select[gt];
      end else if (gt == TERM_SECOND) begin : g_second
        assign fn_eff[gt] = cfg.two_wire_init ? FN_CODES[F_REV*8 +: 8]
                                              : input_function_select[gt];
      end else begin : g_other
        assign fn_eff[gt] = input_function_select[gt];
      end
      for (gf = 0; gf < NFN; gf++) begin : g_fn
        assign hit[gf][gt] = (fn_eff[gt] == FN_CODES[gf*8 +: 8]);
      end
    end
    for (gf = 0; gf < NFN; gf++) begin : g_any
      assign asg[gf] = |hit[gf];
      assign act[gf] = |(hit[gf] & term_r);
    end
  endgenerate

  // ----------------------------------------
  // run, direction and enable
  // ----------------------------------------
  logic cfg_err; // illegal function assignment
  logic both_dir; // forward and reverse both closed
  logic run_raw; // some run input asks to run
  logic rev_raw; // reverse selected
  logic enabled; // enable closed or not assigned
  logic lock_r, lock_nxt; // run held off until recycled
  logic hsb_r, hsb_nxt; // slip braking latched
  logic dcb_r, dcb_nxt; // dc braking active
  logic stc_prev_r, stc_prev_nxt; // cancel input one cycle back
  logic run_ok; // run after every veto
  // illegal assignments block every run command
  always_comb begin
    // each pair below excludes the other; up/down must come together
    cfg_err = ((asg[F_FWD] | asg[F_REV]) & (asg[F_RUN2] | asg[F_DIR2]))
            | (asg[F_SS1] & asg[F_SS2])
            | (asg[F_KNC] & asg[F_KNO])
            | (asg[F_UP2] ^ asg[F_DN2]);
    both_dir = act[F_FWD] & act[F_REV];
    run_raw = (act[F_FWD] ^ act[F_REV]) | act[F_RUN2];
    rev_raw = act[F_REV] | (act[F_RUN2] & act[F_DIR2]);
    // an unassigned enable counts as closed
    enabled = !asg[F_EN] | act[F_EN];
  end

  // run lock and braking latches
  always_comb begin
    // lock remembers a run that was present while disabled
    lock_nxt = lock_r;
    if (!run_raw) begin
      lock_nxt = 1'b0;
    end else if (!enabled) begin
      lock_nxt = 1'b1;
    end
    // hsb holds until stopped and its input is removed
    hsb_nxt = hsb_r;
    if (act[F_HSB]) begin
      hsb_nxt = 1'b1;
    end else if (motor_stopped) begin
      hsb_nxt = 1'b0;
    end
    // braking ends as soon as run or jog appears, so the two never overlap
    dcb_nxt = dcb_r;
    if (run_raw | jog_cmd | !act[F_DCB]) begin
      dcb_nxt = 1'b0;
    end else if (motor_stopped) begin
      dcb_nxt = 1'b1;
    end
    stc_prev_nxt = act[F_STC];
    run_ok = run_raw & enabled & !lock_r & !cfg_err & !both_dir
           & !hsb_r & !act[F_HSB];
  end
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      lock_r <= 1'b0;
      hsb_r <= 1'b0;
      dcb_r <= 1'b0;
      stc_prev_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      hsb_r <= hsb_nxt;
      dcb_r <= dcb_nxt;
      stc_prev_r <= stc_prev_nxt;
    end
  end

  // ----------------------------------------
  // command word
  // ----------------------------------------
  rifd_cmd_t cmd_nxt;
  logic ct_ok_nxt; // loopback verdict for this cycle
  logic fold_nxt; // bias fold pulse for this cycle
  // every field is registered so outputs come from flops
  // settings and codes act after one edge, terminals after three
  always_comb begin
    cmd_nxt = '0;
    cmd_nxt.run = run_ok;
    cmd_nxt.reverse = rev_raw;
    cmd_nxt.external_fault_code = both_dir;
    cmd_nxt.input_assignment_error = cfg_err;
    cmd_nxt.disabled_indication = !enabled;
    // a single pulse: run drops on the same edge
    cmd_nxt.stop_req = cmd_r.run & !enabled;
    cmd_nxt.stop_method = cfg.stop_method_select;
    cmd_nxt.dc_brake = dcb_nxt;
    cmd_nxt.speed_search = cfg.speed_search_at_start | act[F_SS1] | act[F_SS2];
    cmd_nxt.field_weaken = cfg.vf_control & act[F_FW];
    cmd_nxt.kinetic_ride_through = (asg[F_KNC] & !act[F_KNC]) | act[F_KNO];
    cmd_nxt.high_slip_braking = hsb_r | act[F_HSB];
    cmd_nxt.pid_invert = act[F_PIDL];
    cmd_nxt.seq_timer_disable = act[F_STD];
    cmd_nxt.seq_timer_cancel = act[F_STC] & !stc_prev_r;
    cmd_nxt.comm_test = act[F_CTST];
    cmd_nxt.comm_test_ok = ct_ok_nxt;
    cmd_nxt.bias_fold = fold_nxt;
  end

  // ----------------------------------------
  // communication loopback test
  // ----------------------------------------
  logic [15:0] lfsr_r, lfsr_nxt; // pattern generator
  logic sent_r, sent_nxt; // a bit already stands on the line
  logic ct_ok_r; // no mismatch since the test began
  logic tx_nxt; // next transmit level
  // one bit sent per cycle; the looped line returns it while it stands
  // transmit idles high when no test runs, like an idle serial line
  always_comb begin
    lfsr_nxt = lfsr_r;
    sent_nxt = 1'b0;
    tx_nxt = 1'b1;
    ct_ok_nxt = 1'b0;
    if (act[F_CTST]) begin
      lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
      tx_nxt = lfsr_r[0];
      sent_nxt = 1'b1;
      // a single mismatch clears ok until the test restarts
      ct_ok_nxt = sent_r ? (ct_ok_r & (comm_rx == comm_tx_r)) : 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      lfsr_r <= LFSR_SEED;
      sent_r <= 1'b0;
      ct_ok_r <= 1'b0;
      comm_tx_r <= 1'b1;
    end else begin
      lfsr_r <= lfsr_nxt;
      sent_r <= sent_nxt;
      ct_ok_r <= ct_ok_nxt;
      comm_tx_r <= tx_nxt;
    end
  end

  // ----------------------------------------
  // frequency bias
  // ----------------------------------------
  localparam int TW = $clog2(BIAS_TICK_CYC + 1);
  localparam int FW = $clog2(FOLD_CYC + 1);
  logic [TW-1:0] tick_r, tick_nxt;
  logic [FW-1:0] still_r, still_nxt;
  logic [REF_W-1:0] ref_prev_r;
  logic [REF_W-1:0] ref_prev_nxt;
  logic signed [BIAS_W-1:0] bias_nxt;
  logic signed [BIAS_W:0] bias_sum;
  logic up; // lone up input
  logic dn; // lone down input
  logic tick; // bias step instant
  // bias moves one step per tick; a lone input moves it, neither or both hold
  // tick spacing sets the ramp rate; the step itself is a setting
  always_comb begin
    up = act[F_UP2] & !act[F_DN2];
    dn = act[F_DN2] & !act[F_UP2];
    tick = (tick_r == TW'(BIAS_TICK_CYC - 1));
    tick_nxt = tick ? '0 : tick_r + 1'b1;
    bias_nxt = bias_r;
    bias_sum = {bias_r[BIAS_W-1], bias_r};
    fold_nxt = 1'b0;
    still_nxt = still_r;
    ref_prev_nxt = ref_step;
    if (tick & up) begin
      bias_sum = bias_sum + $signed({1'b0, cfg.bias_step_amount});
    end else if (tick & dn) begin
      bias_sum = bias_sum - $signed({1'b0, cfg.bias_step_amount});
    end
    // clamp to the configured limits
    // limits are inclusive and are trusted to keep lower below upper
    if (bias_sum > $signed({cfg.bias_upper_limit[BIAS_W-1], cfg.bias_upper_limit})) begin
      bias_nxt = cfg.bias_upper_limit;
    end else if (bias_sum < $signed({cfg.bias_lower_limit[BIAS_W-1],
                                     cfg.bias_lower_limit})) begin
      bias_nxt = cfg.bias_lower_limit;
    end else begin
      bias_nxt = bias_sum[BIAS_W-1:0];
    end
    if (cfg.multi_step_ref) begin
      // a reference change zeroes the bias before any fold can happen
      if (ref_step != ref_prev_r) begin
        bias_nxt = '0;
        still_nxt = '0;
      end else if (up | dn | (bias_r == '0)) begin
        still_nxt = '0;
      end else if (still_r == FW'(FOLD_CYC - 1)) begin
        fold_nxt = 1'b1;
        bias_nxt = '0;
        still_nxt = '0;
      end else begin
        still_nxt = still_r + 1'b1;
      end
    end else begin
      still_nxt = '0;
    end
  end
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      tick_r <= '0;
      still_r <= '0;
      ref_prev_r <= '0;
      bias_r <= '0;
      cmd_r <= '0;
    end else begin
      tick_r <= tick_nxt;
      still_r <= still_nxt;
      ref_prev_r <= ref_prev_nxt;
      bias_r <= bias_nxt;
      cmd_r <= cmd_nxt;
    end
  end
endmodule

//--- tb/rifd_contacts.sv
// far-side model: dry contacts on the terminals plus the tx/rx jumper
// assumes the bench moves contact requests on the falling clock edge
`timescale 1ns/1ns
module rifd_contacts (
  input wire logic [rifd_pkg::NTERM-1:0] close_req, // contacts to close
  input wire logic loop_break, // jumper pulled off
  input wire logic comm_tx_r, // drive transmit line
  output logic [rifd_pkg::NTERM-1:0] term_in, // terminal levels, 1 = closed
  output logic comm_rx // drive receive line
);
  // ---------------------------------------------
  // contacts and jumper
  // ---------------------------------------------
  // contacts carry no bounce, so level simply follows the request
  assign term_in = close_req;
  // the jumper is a plain wire; pulled off, the line reads the inverse
  assign comm_rx = loop_break ? ~comm_tx_r : comm_tx_r;
endmodule

//--- tb/rifd_decoder_asserts.sv
// port checker for the decoder top
// assumes two-wire init puts forward/reverse on terminals 0 and 1
`timescale 1ns/1ns
module rifd_decoder_asserts
  import rifd_pkg::*;
#(
  parameter int NT = 8,
  parameter int FOLD_CYC = 200
) (
  input wire logic clk, // control clock
  input wire logic reset_n, // async reset, low
  input wire logic [NT-1:0] term_in, // terminals
  input wire rifd_pkg::rifd_cfg_t cfg, // settings
  input wire rifd_pkg::rifd_cmd_t cmd_r, // commands
  input wire logic signed [rifd_pkg::BIAS_W-1:0] bias_r // bias
);
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_fault_blocks_run: assert property (cmd_r.external_fault_code |-> !cmd_r.run)
    else $error("run while fault");
  a_err_blocks_run: assert property (cmd_r.input_assignment_error |-> !cmd_r.run)
    else $error("run while assignment error");
  a_dis_blocks_run: assert property (cmd_r.disabled_indication |-> !cmd_r.run)
    else $error("run while disabled");
  // direction comes from the snapshot taken three edges back
  a_dir_follows: assert property (cfg.two_wire_init && cmd_r.run
    |-> cmd_r.reverse == $past(term_in[1], 3)) else $error("direction wrong");
  a_both_fault: assert property (cfg.two_wire_init && !cmd_r.input_assignment_error
    && $past(term_in[1:0], 3) == 2'h3 |-> cmd_r.external_fault_code)
    else $error("both closed without fault");
  a_brake_no_run: assert property (cmd_r.dc_brake |-> !cmd_r.run)
    else $error("braking while running");
  a_cancel_pulse: assert property ($rose(cmd_r.seq_timer_cancel) |=> !cmd_r.seq_timer_cancel)
    else $error("cancel longer than a cycle");
  a_stop_method: assert property (cmd_r.stop_req |-> $past(cmd_r.run)
    && cmd_r.stop_method == cfg.stop_method_select ##1 !cmd_r.stop_req)
    else $error("stop request wrong");
  a_bias_limits: assert property (bias_r <= cfg.bias_upper_limit
    && bias_r >= cfg.bias_lower_limit) else $error("bias out of limits");
  a_fold_clears: assert property (cmd_r.bias_fold |=> bias_r == 0)
    else $error("bias kept after fold");
  c_stop: cover property (cmd_r.stop_req);
  c_fault: cover property (cmd_r.external_fault_code);
  c_fold: cover property (cmd_r.bias_fold);
  c_ctest: cover property (cmd_r.comm_test_ok);
endmodule

//--- tb/test_run_input_function_decoder.sv
// self-checking bench for the run input function decoder
// assumes the contact model on the far side and a short fold count
`timescale 1ns/1ns
module test_run_input_function_decoder;
  import rifd_pkg::*;
  // ---------------------------------------------
  // bench signals and helpers
  // ---------------------------------------------
  localparam logic [23:0] ETAB [5] = '{24'h420001, 24'h616201, 24'h656601,
    24'h750001, 24'h757600};
  logic clk = 0;
  logic reset_n = 0;
  logic [7:0] req = 8'h04;
  logic brk = 0;
  logic stopped = 0;
  logic jog = 0;
  logic [3:0] step = 4'h0;
  logic [7:0] term;
  logic rx, tx;
  rifd_fn_t [7:0] fsel = {8'h63, 8'h67, 8'h52, 8'h35, 8'h60, 8'h6a, 8'h00, 8'h00};
  rifd_cfg_t cfg = '0;
  rifd_cmd_t cmd;
  logic signed [15:0] bias;
  logic [31:0] seed = 32'h4f4b7df8;
  int err_count = 0;
  int n_checks = 0;
  int k, n;
  initial begin
    forever #5 clk = ~clk;
  end
  rifd_contacts i_far (.close_req(req), .loop_break(brk), .comm_tx_r(tx),
    .term_in(term), .comm_rx(rx));
  rifd_decoder #(.FOLD_CYC(200)) i_dut (.clk(clk), .reset_n(reset_n), .term_in(term),
    .input_function_select(fsel), .cfg(cfg), .motor_stopped(stopped), .jog_cmd(jog),
    .ref_step(step), .comm_rx(rx), .comm_tx_r(tx), .cmd_r(cmd), .bias_r(bias));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // fault, reverse, run expected from the forward/reverse pair
  function automatic logic [2:0] exp_dir(input logic [1:0] t);
    return {&t, t[1], ^t};
  endfunction
  // run and reverse expected from the run/direction pair of scheme two
  function automatic logic [1:0] exp_run2(input logic [1:0] t);
    return {t[0], t[0] & t[1]};
  endfunction
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // a hang anywhere ends the run as a mismatch
  initial begin
    #500000;
    $display("BAD watchdog exp done got hang");
    err_count++;
    tally_and_finish();
  end
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  initial begin
    cfg.two_wire_init = 1;
    cfg.vf_control = 1;
    cfg.stop_method_select = 2'h2;
    cfg.bias_step_amount = 16'h0028;
    cfg.bias_upper_limit = 16'sh0064;
    cfg.bias_lower_limit = -16'sh0064;
    cyc(8);
    reset_n = 1;
    cyc(4);
    // random contacts, the four pair states forced first
    for (k = 0; k < 40; k++) begin
      seed = xs(seed);
      req = {seed[2], 2'h0, seed[3], 2'h1, seed[1:0]};
      if (k < 4) req[1:0] = k[1:0];
      cyc(4);
      chk("dir", 16'(exp_dir(req[1:0])), 16'({cmd.external_fault_code, cmd.reverse, cmd.run}));
      chk("fw", 16'(req[7]), 16'(cmd.field_weaken));
      chk("pid", 16'(req[4]), 16'(cmd.pid_invert));
    end
    req = 8'h05;
    cyc(4);
    req = 8'h01;
    n = 0;
    repeat (4) begin
      cyc(1);
      if (cmd.stop_req === 1'b1) n++;
    end
    chk("stop_req", 16'h1, 16'(n));
    chk("dis", 16'ha, 16'({cmd.stop_method, cmd.disabled_indication, cmd.run}));
    req = 8'h05;
    cyc(4);
    chk("lock", 16'h0, 16'(cmd.run));
    req = 8'h04;
    cyc(4);
    req = 8'h05;
    cyc(4);
    chk("rerun", 16'h1, 16'(cmd.run));
    req = 8'h04;
    stopped = 1;
    cyc(4);
    req = 8'h0c;
    cyc(4);
    chk("dcb", 16'h1, 16'(cmd.dc_brake));
    jog = 1;
    cyc(3);
    chk("dcb_jog", 16'h0, 16'(cmd.dc_brake));
    jog = 0;
    req = 8'h24;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (cmd.seq_timer_cancel === 1'b1) n++;
    end
    chk("cancel", 16'h1, 16'(n));
    req = 8'h44;
    for (k = 0; k < 50 && cmd.comm_test_ok !== 1'b1; k++) cyc(1);
    chk("ctest", 16'h3, 16'({cmd.comm_test, cmd.comm_test_ok}));
    brk = 1;
    cyc(4);
    chk("ctest_brk", 16'h2, 16'({cmd.comm_test, cmd.comm_test_ok}));
    brk = 0;
    req = 8'h04;
    // illegal pairings and one legal up/down pair on two otherwise idle terminals
    for (k = 0; k < 5; k++) begin
      fsel[3] = ETAB[k][23:16];
      fsel[5] = ETAB[k][15:8];
      cyc(3);
      chk("cfg_err", 16'(ETAB[k][0]), 16'(cmd.input_assignment_error));
    end
    fsel[3] = 8'h61;
    fsel[5] = 8'h65;
    req = 8'h0c;
    cyc(4);
    chk("ss_krt", 16'h3, 16'({cmd.speed_search, cmd.kinetic_ride_through}));
    req = 8'h2c;
    cyc(4);
    chk("ss_krt2", 16'h2, 16'({cmd.speed_search, cmd.kinetic_ride_through}));
    fsel[3] = 8'h75;
    fsel[5] = 8'h76;
    cfg.multi_step_ref = 1;
    req = 8'h0c;
    cyc(4000);
    chk("bias_up", 16'h0064, bias);
    req = 8'h24;
    cyc(6000);
    chk("bias_dn", 16'hff9c, bias);
    req = 8'h04;
    n = 0;
    repeat (250) begin
      cyc(1);
      if (cmd.bias_fold === 1'b1) n++;
    end
    chk("fold_pulse", 16'h1, 16'(n));
    chk("bias_fold", 16'h0, bias);
    req = 8'h0c;
    cyc(1100);
    req = 8'h04;
    chk("bias_some", 16'h1, 16'(bias != 0));
    cyc(20);
    step = 4'h1;
    cyc(3);
    chk("bias_step", 16'h0, bias);
    // scheme two on the first terminals, timer disable and slip braking beside it
    cfg.two_wire_init = 0;
    cfg.multi_step_ref = 0;
    cfg.speed_search_at_start = 1;
    fsel[0] = 8'h42;
    fsel[1] = 8'h43;
    fsel[3] = 8'h51;
    fsel[5] = 8'h68;
    for (k = 0; k < 12; k++) begin
      seed = xs(seed);
      req = {4'h0, seed[3], 1'b1, seed[1:0]};
      if (k < 4) req[1:0] = k[1:0];
      cyc(4);
      chk("run2", 16'(exp_run2(req[1:0])), 16'({cmd.run, cmd.reverse}));
      chk("std", 16'(req[3]), 16'(cmd.seq_timer_disable));
      chk("ss_start", 16'h1, 16'(cmd.speed_search));
    end
    req = 8'h25;
    cyc(4);
    chk("hsb", 16'h2, 16'({cmd.high_slip_braking, cmd.run}));
    req = 8'h05;
    stopped = 0;
    cyc(4);
    chk("hsb_hold", 16'h2, 16'({cmd.high_slip_braking, cmd.run}));
    stopped = 1;
    cyc(4);
    chk("hsb_done", 16'h1, 16'({cmd.high_slip_braking, cmd.run}));
    tally_and_finish();
  end
endmodule
bind rifd_decoder rifd_decoder_asserts #(.NT(NT), .FOLD_CYC(FOLD_CYC)) i_chk (.clk(clk),
  .reset_n(reset_n), .term_in(term_in), .cfg(cfg), .cmd_r(cmd_r), .bias_r(bias_r));
